// ### design/lsce_map.svh
// Overview of operation
// R1 - Link-up bit follows established link state
// R2 - Sync bit reads live request, 0 asserted
// R3 - Sticky realign flag on phase-shifting SYSREF
// R4 - Sticky align flag on first SYSREF after enable
// R5 - Serial PLL lock bit follows lock
// R6 - Converter PLL lock bit follows lock
// R7 - Solo mode disables channels B, C, D
// R8 - Software keeps first pair on in solo
// R9 - Second pair enable drives C, D; resets 1
// R10 - First pair enable drives A, B; resets 1
// R11 - Software stops calibration, link before changes
// R12 - Software never disables both pairs together
// R13 - One pair off halves lanes and converters
// R14 - Odd lane count pads highest lane tail
// R15 - First pair off moves C, D samples forward
// R16 - Software writes zeros to upper bits
// R17 - Zero writes change nothing; a one clears its sticky status flag
`ifndef LSCE_MAP_SVH
`define LSCE_MAP_SVH

// ****************************************
// Register offsets
// ****************************************
`define LSCE_OFS_STATUS 10'h208
`define LSCE_OFS_CHEN 10'h209
`define LSCE_OFS_CTRL 10'h20A
`define LSCE_OFS_IRQ_STAT 10'h20B
`define LSCE_OFS_IRQ_MASK 10'h20C

// ****************************************
// Status fields
// ****************************************
`define LSCE_ST_LINK_UP 6
`define LSCE_ST_SYNC 5
`define LSCE_ST_REALIGNED 4
`define LSCE_ST_MULTIFRAME_PHASE_SET_FLAG 3
`define LSCE_ST_SPLL 2
`define LSCE_ST_CPLL 0

// ****************************************
// Channel enable fields and reset
// ****************************************
`define LSCE_CH_SOLO 2
`define LSCE_CH_SECOND 1
`define LSCE_CH_FIRST 0
`define LSCE_CHEN_RESET 3'h3

// ****************************************
// Control and interrupt fields
// ****************************************
`define LSCE_CTRL_LINK_EN 0
`define LSCE_CTRL_RESET 1'h0
`define LSCE_IRQ_MULTIFRAME_PHASE_SET_FLAG 0
`define LSCE_IRQ_REALIGNED 1
`define LSCE_IRQ_LINK_LOST 2
`define LSCE_IRQ_PLL_LOST 3
`define LSCE_IRQ_BITS 4
`define LSCE_IRQ_RESET 4'h0

`endif

// ### design/lsce_pkg.sv
`default_nettype none
package lsce_pkg;
  typedef logic [9:0] lsce_addr_type;
  typedef logic [7:0] lsce_byte_type;
  typedef enum logic [1:0] {
    ALIGN_IDLE,
    ALIGN_ARMED,
    ALIGN_DONE
  } lsce_align_state_type;
endpackage
`default_nettype wire

// ### design/lsce_sync3.sv
`default_nettype none
module lsce_sync3 #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic async_in,
  output logic sync_out
);
  logic stage1_reg;
  logic stage2_reg;
  logic stage3_reg;

  // ****************************************
  // Three flops; accept only when 2 and 3 agree
  // ****************************************
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      stage1_reg <= RESET_VAL;
      stage2_reg <= RESET_VAL;
      stage3_reg <= RESET_VAL;
    end else begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // Filters a single-cycle glitch past the metastable stage
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sync_out <= RESET_VAL;
    end else if (stage2_reg == stage3_reg) begin
      sync_out <= stage3_reg;
    end
  end
endmodule
`default_nettype wire

// ### design/lsce_sticky.sv
`default_nettype none
module lsce_sticky (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic set_pulse,
  input wire logic clear_pulse,
  output logic flag
);
  // ****************************************
  // Set beats clear so no event is lost
  // ****************************************
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      flag <= 1'b0;
    end else if (set_pulse) begin
      flag <= 1'b1;
    end else if (clear_pulse) begin
      flag <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### design/lsce_top.sv
// The address-and-strobe port was left to the implementer.
`include "lsce_map.svh"
`default_nettype none
module lsce_top #(
  parameter int LANE_W = 4,
  parameter int CONV_W = 4
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire lsce_pkg::lsce_addr_type reg_addr,
  input wire lsce_pkg::lsce_byte_type reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output lsce_pkg::lsce_byte_type reg_rdata,
  input wire logic link_up_pin,
  input wire logic sync_req_n_pin,
  input wire logic serial_pll_lock_pin,
  input wire logic converter_pll_lock_pin,
  input wire logic sysref_pin,
  input wire logic sysref_phase_moved,
  input wire logic [LANE_W-1:0] full_lane_count,
  input wire logic [CONV_W-1:0] full_conv_count,
  output logic link_enable,
  output logic channel_a_enable,
  output logic channel_b_enable,
  output logic channel_c_enable,
  output logic channel_d_enable,
  output logic [LANE_W-1:0] lane_count,
  output logic [CONV_W-1:0] conv_count,
  output logic tail_pad_enable,
  output logic cd_in_ab_slots,
  output logic irq
);
  import lsce_pkg::*;
  // ****************************************
  // Synchronised pin levels
  // ****************************************
  logic link_up_sync;
  logic sync_req_n_sync;
  logic serial_pll_lock;
  logic converter_pll_lock;
  logic sysref_sync;

  lsce_sync3 #(
    .RESET_VAL(1'b0)
  ) u_sync_link (
    .sys_clk(sys_clk),
    .reset(reset),
    .async_in(link_up_pin),
    .sync_out(link_up_sync)
  );
  // Request released until the receiver says otherwise
  lsce_sync3 #(
    .RESET_VAL(1'b1)
  ) u_sync_req (
    .sys_clk(sys_clk),
    .reset(reset),
    .async_in(sync_req_n_pin),
    .sync_out(sync_req_n_sync)
  );
  lsce_sync3 #(
    .RESET_VAL(1'b0)
  ) u_sync_spll (
    .sys_clk(sys_clk),
    .reset(reset),
    .async_in(serial_pll_lock_pin),
    .sync_out(serial_pll_lock)
  );
  lsce_sync3 #(
    .RESET_VAL(1'b0)
  ) u_sync_cpll (
    .sys_clk(sys_clk),
    .reset(reset),
    .async_in(converter_pll_lock_pin),
    .sync_out(converter_pll_lock)
  );
  lsce_sync3 #(
    .RESET_VAL(1'b0)
  ) u_sync_sysref (
    .sys_clk(sys_clk),
    .reset(reset),
    .async_in(sysref_pin),
    .sync_out(sysref_sync)
  );

  // ****************************************
  // Edge detection on settled levels
  // ****************************************
  logic sysref_prev_reg;
  logic link_up_prev_reg;
  logic spll_prev_reg;
  logic cpll_prev_reg;
  logic sysref_edge;
  logic link_lost;
  logic pll_lost;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sysref_prev_reg <= 1'b0;
      link_up_prev_reg <= 1'b0;
      spll_prev_reg <= 1'b0;
      cpll_prev_reg <= 1'b0;
    end else begin
      sysref_prev_reg <= sysref_sync;
      link_up_prev_reg <= link_up_sync;
      spll_prev_reg <= serial_pll_lock;
      cpll_prev_reg <= converter_pll_lock;
    end
  end

  assign sysref_edge = sysref_sync & ~sysref_prev_reg;
  assign link_lost = link_up_prev_reg & ~link_up_sync;
  assign pll_lost = (spll_prev_reg & ~serial_pll_lock) |
                    (cpll_prev_reg & ~converter_pll_lock);

  // ****************************************
  // Bus decode
  // ****************************************
  logic wr_status;
  logic wr_chen;
  logic wr_ctrl;
  logic wr_irq_stat;
  logic wr_irq_mask;

  assign wr_status = reg_wr && (reg_addr == `LSCE_OFS_STATUS);
  assign wr_chen = reg_wr && (reg_addr == `LSCE_OFS_CHEN);
  assign wr_ctrl = reg_wr && (reg_addr == `LSCE_OFS_CTRL);
  assign wr_irq_stat = reg_wr && (reg_addr == `LSCE_OFS_IRQ_STAT);
  assign wr_irq_mask = reg_wr && (reg_addr == `LSCE_OFS_IRQ_MASK);

  // ****************************************
  // Control register
  // ****************************************
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      link_enable <= `LSCE_CTRL_RESET;
    end else if (wr_ctrl) begin
      link_enable <= reg_wdata[`LSCE_CTRL_LINK_EN];
    end
  end

  // ****************************************
  // Alignment tracking
  // ****************************************
  lsce_align_state_type align_state_reg;
  lsce_align_state_type align_state_next;
  logic multiframe_phase_set_flag_set;
  logic realigned_set;
  logic multiframe_phase_set_flag_flag;
  logic realigned_flag;

  // Rearms each time the link encoder is switched on again
  always_comb begin
    align_state_next = align_state_reg;
    unique case (align_state_reg)
      ALIGN_IDLE: begin
        if (link_enable) begin
          align_state_next = ALIGN_ARMED;
        end
      end
      ALIGN_ARMED: begin
        if (!link_enable) begin
          align_state_next = ALIGN_IDLE;
        end else if (sysref_edge) begin
          align_state_next = ALIGN_DONE;
        end
      end
      ALIGN_DONE: begin
        if (!link_enable) begin
          align_state_next = ALIGN_IDLE;
        end
      end
      default: begin
        align_state_next = ALIGN_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      align_state_reg <= ALIGN_IDLE;
    end else begin
      align_state_reg <= align_state_next;
    end
  end

  assign multiframe_phase_set_flag_set = (align_state_reg == ALIGN_ARMED) && link_enable && sysref_edge; // R4
  assign realigned_set = sysref_edge && sysref_phase_moved; // R3

  // Only a one in the flag's position clears it
  lsce_sticky u_multiframe_phase_set_flag (
    .sys_clk(sys_clk),
    .reset(reset),
    .set_pulse(multiframe_phase_set_flag_set),
    .clear_pulse(wr_status && reg_wdata[`LSCE_ST_MULTIFRAME_PHASE_SET_FLAG]), // R4 R17
    .flag(multiframe_phase_set_flag_flag)
  );

  lsce_sticky u_realigned (
    .sys_clk(sys_clk),
    .reset(reset),
    .set_pulse(realigned_set),
    .clear_pulse(wr_status && reg_wdata[`LSCE_ST_REALIGNED]), // R3 R17
    .flag(realigned_flag)
  );

  // ****************************************
  // Channel pair enable register
  // ****************************************
  logic solo_channel_mode;
  logic second_pair_enable;
  logic first_pair_enable;

  // Upper bits are not stored and read back as zero
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      {solo_channel_mode, second_pair_enable, first_pair_enable} <= `LSCE_CHEN_RESET; // R9 R10
    end else if (wr_chen) begin
      solo_channel_mode <= reg_wdata[`LSCE_CH_SOLO];
      second_pair_enable <= reg_wdata[`LSCE_CH_SECOND];
      first_pair_enable <= reg_wdata[`LSCE_CH_FIRST];
    end
  end

  // ****************************************
  // Channel enables and link shape
  // ****************************************
  logic one_pair_off;
  logic [LANE_W-1:0] half_lanes;
  logic [CONV_W-1:0] half_convs;

  // Both pairs off is undefined; it is treated like one pair off
  assign one_pair_off = ~first_pair_enable | ~second_pair_enable;
  assign half_lanes = LANE_W'((LANE_W+1)'(full_lane_count) + (LANE_W+1)'(1) >> 1);
  assign half_convs = full_conv_count >> 1;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      channel_a_enable <= 1'b0;
      channel_b_enable <= 1'b0;
      channel_c_enable <= 1'b0;
      channel_d_enable <= 1'b0;
    end else begin
      channel_a_enable <= first_pair_enable; // R10
      channel_b_enable <= first_pair_enable & ~solo_channel_mode; // R7 R10
      channel_c_enable <= second_pair_enable & ~solo_channel_mode; // R7 R9
      channel_d_enable <= second_pair_enable & ~solo_channel_mode; // R7 R9
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      lane_count <= '0;
      conv_count <= '0;
      tail_pad_enable <= 1'b0;
    end else if (one_pair_off) begin
      lane_count <= half_lanes; // R13
      conv_count <= half_convs; // R13
      tail_pad_enable <= full_lane_count[0]; // R14
    end else begin
      lane_count <= full_lane_count;
      conv_count <= full_conv_count;
      tail_pad_enable <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cd_in_ab_slots <= 1'b0;
    end else begin
      cd_in_ab_slots <= ~first_pair_enable; // R15
    end
  end

  // ****************************************
  // Interrupt status and mask
  // ****************************************
  logic [`LSCE_IRQ_BITS-1:0] irq_events;
  logic [`LSCE_IRQ_BITS-1:0] irq_status;
  logic [`LSCE_IRQ_BITS-1:0] irq_mask_reg;

  always_comb begin
    irq_events = '0;
    irq_events[`LSCE_IRQ_MULTIFRAME_PHASE_SET_FLAG] = multiframe_phase_set_flag_set;
    irq_events[`LSCE_IRQ_REALIGNED] = realigned_set;
    irq_events[`LSCE_IRQ_LINK_LOST] = link_lost;
    irq_events[`LSCE_IRQ_PLL_LOST] = pll_lost;
  end

  for (genvar i = 0; i < `LSCE_IRQ_BITS; i++) begin : g_irq
    lsce_sticky u_irq_bit (
      .sys_clk(sys_clk),
      .reset(reset),
      .set_pulse(irq_events[i]),
      .clear_pulse(wr_irq_stat && reg_wdata[i]),
      .flag(irq_status[i])
    );
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      irq_mask_reg <= `LSCE_IRQ_RESET;
    end else if (wr_irq_mask) begin
      irq_mask_reg <= reg_wdata[`LSCE_IRQ_BITS-1:0];
    end
  end

  // Registered so the output is glitch free; lags status by one cycle
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask_reg);
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  lsce_byte_type status_view;
  lsce_byte_type read_mux;

  always_comb begin
    status_view = '0;
    status_view[`LSCE_ST_LINK_UP] = link_up_sync; // R1
    status_view[`LSCE_ST_SYNC] = sync_req_n_sync; // R2
    status_view[`LSCE_ST_REALIGNED] = realigned_flag; // R3
    status_view[`LSCE_ST_MULTIFRAME_PHASE_SET_FLAG] = multiframe_phase_set_flag_flag; // R4
    status_view[`LSCE_ST_SPLL] = serial_pll_lock; // R5
    status_view[`LSCE_ST_CPLL] = converter_pll_lock; // R6
  end

  always_comb begin
    read_mux = '0;
    unique case (reg_addr)
      `LSCE_OFS_STATUS: begin
        read_mux = status_view;
      end
      `LSCE_OFS_CHEN: begin
        read_mux[`LSCE_CH_SOLO] = solo_channel_mode;
        read_mux[`LSCE_CH_SECOND] = second_pair_enable;
        read_mux[`LSCE_CH_FIRST] = first_pair_enable;
      end
      `LSCE_OFS_CTRL: begin
        read_mux[`LSCE_CTRL_LINK_EN] = link_enable;
      end
      `LSCE_OFS_IRQ_STAT: begin
        read_mux[`LSCE_IRQ_BITS-1:0] = irq_status;
      end
      `LSCE_OFS_IRQ_MASK: begin
        read_mux[`LSCE_IRQ_BITS-1:0] = irq_mask_reg;
      end
      default: begin
        read_mux = '0;
      end
    endcase
  end

  // Data valid only in the cycle after the strobe
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= read_mux;
    end else begin
      reg_rdata <= '0;
    end
  end
endmodule
`default_nettype wire

// ### test/lsce_top_props.sv
`include "lsce_map.svh"
`default_nettype none
module lsce_top_props #(
  parameter int LANE_W = 4,
  parameter int CONV_W = 4
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire lsce_pkg::lsce_addr_type reg_addr,
  input wire lsce_pkg::lsce_byte_type reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire lsce_pkg::lsce_byte_type reg_rdata,
  input wire logic link_up_pin,
  input wire logic sync_req_n_pin,
  input wire logic serial_pll_lock_pin,
  input wire logic converter_pll_lock_pin,
  input wire logic [LANE_W-1:0] full_lane_count,
  input wire logic [CONV_W-1:0] full_conv_count,
  input wire logic channel_a_enable,
  input wire logic channel_b_enable,
  input wire logic channel_c_enable,
  input wire logic channel_d_enable,
  input wire logic [LANE_W-1:0] lane_count,
  input wire logic [CONV_W-1:0] conv_count,
  input wire logic tail_pad_enable,
  input wire logic cd_in_ab_slots
);
  import lsce_pkg::*;
  logic [3:0] pin_age;
  logic ch_wr;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // ****************************************
  // Pin age, so synchroniser delay is out of the way
  // ****************************************
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pin_age <= 4'h0;
    end else if ($changed({link_up_pin, sync_req_n_pin, serial_pll_lock_pin,
                           converter_pll_lock_pin})) begin
      pin_age <= 4'h0;
    end else if (pin_age != 4'h8) begin
      pin_age <= pin_age + 4'h1;
    end
  end
  assign ch_wr = reg_wr && reg_addr == `LSCE_OFS_CHEN;
  // ****************************************
  // Assertions
  // ****************************************
  a_link_up_bit:
    assert property (reg_rd && reg_addr == `LSCE_OFS_STATUS && pin_age == 4'h8
      |=> reg_rdata[6] == $past(link_up_pin)) else $error("link bit wrong");
  a_sync_live_bit:
    assert property (reg_rd && reg_addr == `LSCE_OFS_STATUS && pin_age == 4'h8
      |=> reg_rdata[5] == $past(sync_req_n_pin)) else $error("sync bit wrong");
  a_pll_lock_bits:
    assert property (reg_rd && reg_addr == `LSCE_OFS_STATUS && pin_age == 4'h8
      |=> reg_rdata[2] == $past(serial_pll_lock_pin)
      && reg_rdata[0] == $past(converter_pll_lock_pin)) else $error("lock bit wrong");
  // Register bits land at the write edge, outputs one edge later
  a_solo_blocks:
    assert property (ch_wr && reg_wdata[2]
      |=> ##1 !channel_b_enable && !channel_c_enable && !channel_d_enable)
      else $error("solo left a channel on");
  a_second_pair:
    assert property (ch_wr && !reg_wdata[2]
      |=> ##1 channel_c_enable == $past(reg_wdata[1], 2)
      && channel_d_enable == $past(reg_wdata[1], 2)) else $error("second pair wrong");
  a_first_pair:
    assert property (ch_wr |=> ##1 channel_a_enable == $past(reg_wdata[0], 2))
      else $error("first pair wrong");
  a_lane_halving:
    assert property (ch_wr && (reg_wdata[0] ^ reg_wdata[1])
      |=> ##1 lane_count == LANE_W'(({1'b0, $past(full_lane_count)} + 1'b1) >> 1)
      && conv_count == $past(full_conv_count) >> 1) else $error("counts not halved");
  a_tail_pad:
    assert property (ch_wr && (reg_wdata[0] ^ reg_wdata[1])
      |=> ##1 tail_pad_enable == $past(full_lane_count[0])) else $error("tail pad wrong");
  a_slot_remap:
    assert property (ch_wr |=> ##1 cd_in_ab_slots == !$past(reg_wdata[0], 2))
      else $error("slot remap wrong");
endmodule
bind lsce_top lsce_top_props #(.LANE_W(LANE_W), .CONV_W(CONV_W)) lsce_top_props_i (
  .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_up_pin(link_up_pin),
  .sync_req_n_pin(sync_req_n_pin), .serial_pll_lock_pin(serial_pll_lock_pin),
  .converter_pll_lock_pin(converter_pll_lock_pin), .full_lane_count(full_lane_count),
  .full_conv_count(full_conv_count), .channel_a_enable(channel_a_enable),
  .channel_b_enable(channel_b_enable), .channel_c_enable(channel_c_enable),
  .channel_d_enable(channel_d_enable), .lane_count(lane_count), .conv_count(conv_count),
  .tail_pad_enable(tail_pad_enable), .cd_in_ab_slots(cd_in_ab_slots));
`default_nettype wire

// ### test/lsce_far_end.sv
`default_nettype none
module lsce_far_end (
  input wire logic sys_clk,
  input wire logic link_enable,
  input wire logic spll_ok,
  input wire logic cpll_ok,
  input wire logic ref_go,
  input wire logic shift_go,
  output logic link_up_pin,
  output logic sync_req_n_pin,
  output logic serial_pll_lock_pin,
  output logic converter_pll_lock_pin,
  output logic sysref_pin,
  output logic sysref_phase_moved
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] up_cnt = 4'h0;
  logic [2:0] ref_cnt = 3'h0;
  logic moved = 1'b0;
  // ****************************************
  // Receiver: request held until frames settle
  // ****************************************
  always @(posedge sys_clk) begin
    if (!link_enable) up_cnt <= 4'h0;
    else if (up_cnt != 4'hF) up_cnt <= up_cnt + 4'h1;
  end
  assign link_up_pin = up_cnt == 4'hF;
  assign sync_req_n_pin = up_cnt > 4'h7;
  assign serial_pll_lock_pin = spll_ok;
  assign converter_pll_lock_pin = cpll_ok;
  // Four-cycle pulse, long enough for the input filter
  always @(posedge sys_clk) begin
    if (ref_go || shift_go) ref_cnt <= 3'h4;
    else if (ref_cnt != 3'h0) ref_cnt <= ref_cnt - 3'h1;
    if (ref_go || shift_go) moved <= shift_go;
  end
  assign sysref_pin = ref_cnt != 3'h0;
  assign sysref_phase_moved = moved;
endmodule
`default_nettype wire

// ### test/link_status_channel_enable_tb.sv
`include "lsce_map.svh"
`default_nettype none
module link_status_channel_enable_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lsce_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  lsce_addr_type reg_addr = '0;
  lsce_byte_type reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic spll_ok = 1'b1;
  logic cpll_ok = 1'b1;
  logic ref_go = 1'b0;
  logic shift_go = 1'b0;
  logic [3:0] full_lanes = 4'h5;
  logic [3:0] full_convs = 4'h4;
  logic [3:0] lanes, convs;
  lsce_byte_type reg_rdata, got;
  logic link_up_pin, sync_req_n_pin, spll_pin, cpll_pin, sysref_pin, moved;
  logic link_enable, ch_a, ch_b, ch_c, ch_d, tail_pad, cd_slots, irq;
  int fails = 0;
  int checks_done = 0;
  always #2.5 sys_clk = ~sys_clk;
  lsce_top lsce_top_i (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .link_up_pin(link_up_pin), .sync_req_n_pin(sync_req_n_pin),
    .serial_pll_lock_pin(spll_pin), .converter_pll_lock_pin(cpll_pin),
    .sysref_pin(sysref_pin), .sysref_phase_moved(moved), .full_lane_count(full_lanes),
    .full_conv_count(full_convs), .link_enable(link_enable), .channel_a_enable(ch_a),
    .channel_b_enable(ch_b), .channel_c_enable(ch_c), .channel_d_enable(ch_d),
    .lane_count(lanes), .conv_count(convs), .tail_pad_enable(tail_pad),
    .cd_in_ab_slots(cd_slots), .irq(irq));
  lsce_far_end lsce_far_end_i (.sys_clk(sys_clk), .link_enable(link_enable),
    .spll_ok(spll_ok), .cpll_ok(cpll_ok), .ref_go(ref_go), .shift_go(shift_go),
    .link_up_pin(link_up_pin), .sync_req_n_pin(sync_req_n_pin),
    .serial_pll_lock_pin(spll_pin), .converter_pll_lock_pin(cpll_pin),
    .sysref_pin(sysref_pin), .sysref_phase_moved(moved));
  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task automatic give_verdict();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input lsce_byte_type g, input lsce_byte_type e);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wr(input lsce_addr_type a, input lsce_byte_type d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  // Data stand one cycle only, so sample just after the read edge
  task automatic rd(input lsce_addr_type a, input lsce_byte_type e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 got = reg_rdata;
    @(posedge sys_clk);
    chk(got, e);
  endtask
  task automatic pulse(input logic shift);
    ref_go <= !shift;
    shift_go <= shift;
    @(posedge sys_clk);
    ref_go <= 1'b0;
    shift_go <= 1'b0;
    idle(12);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    idle(8);
    rd(`LSCE_OFS_STATUS, 8'h05);
    rd(`LSCE_OFS_CHEN, 8'h03);
    rd(10'h3FF, 8'h00);
    chk({4'h0, ch_a, ch_b, ch_c, ch_d}, 8'h0F);
  endtask
  task automatic t_levels();
    wr(`LSCE_OFS_CTRL, 8'h01);
    rd(`LSCE_OFS_CTRL, 8'h01);
    chk({7'h00, link_enable}, 8'h01);
    idle(24);
    rd(`LSCE_OFS_STATUS, 8'h65);
    spll_ok <= 1'b0;
    idle(8);
    rd(`LSCE_OFS_STATUS, 8'h61);
    spll_ok <= 1'b1;
    cpll_ok <= 1'b0;
    idle(8);
    rd(`LSCE_OFS_STATUS, 8'h64);
    cpll_ok <= 1'b1;
    wr(`LSCE_OFS_STATUS, 8'hE7);
    idle(8);
    rd(`LSCE_OFS_STATUS, 8'h65);
    chk({7'h00, irq}, 8'h00);
  endtask
  task automatic t_sysref();
    int n;
    wr(`LSCE_OFS_IRQ_MASK, 8'h01);
    pulse(1'b0);
    for (n = 0; n < 40 && irq !== 1'b1; n++) @(posedge sys_clk);
    if (n == 40) begin
      fails++;
      give_verdict();
    end
    rd(`LSCE_OFS_STATUS, 8'h6D);
    pulse(1'b1);
    rd(`LSCE_OFS_STATUS, 8'h7D);
    wr(`LSCE_OFS_STATUS, 8'h00);
    rd(`LSCE_OFS_STATUS, 8'h7D);
    wr(`LSCE_OFS_STATUS, 8'h08);
    rd(`LSCE_OFS_STATUS, 8'h75);
    wr(`LSCE_OFS_STATUS, 8'h10);
    pulse(1'b0);
    rd(`LSCE_OFS_STATUS, 8'h65);
    rd(`LSCE_OFS_IRQ_MASK, 8'h01);
    rd(`LSCE_OFS_IRQ_STAT, 8'h0B);
    chk({7'h00, irq}, 8'h01);
    wr(`LSCE_OFS_IRQ_STAT, 8'h0F);
    rd(`LSCE_OFS_IRQ_STAT, 8'h00);
    chk({7'h00, irq}, 8'h00);
  endtask
  // Pair off halves counts; both pairs off is never written
  task automatic t_channels();
    logic [2:0] mode [4] = '{3'h3, 3'h1, 3'h2, 3'h5};
    logic [2:0] m;
    logic [3:0] lx;
    logic [3:0] mx;
    logic h;
    wr(`LSCE_OFS_CTRL, 8'h00);
    for (int p = 0; p < 2; p++) begin
      lx = 4'h5 + 4'(p);
      full_lanes <= lx;
      mx = 4'h4 + 4'(2 * p);
      full_convs <= mx;
      for (int i = 0; i < 4; i++) begin
        m = mode[i];
        h = m[0] ^ m[1];
        wr(`LSCE_OFS_CHEN, {5'h00, m});
        rd(`LSCE_OFS_CHEN, {5'h00, m});
        chk({4'h0, ch_a, ch_b, ch_c, ch_d}, {4'h0, m[0], m[0] & !m[2], {2{m[1] & !m[2]}}});
        chk({lanes, convs}, {h ? (lx + 4'h1) >> 1 : lx, h ? mx >> 1 : mx});
        chk({6'h00, tail_pad, cd_slots}, {6'h00, h & lx[0], !m[0]});
      end
    end
  endtask
  initial begin
    idle(4);
    reset <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_levels();
    t_sysref();
    t_channels();
    give_verdict();
  end
  initial begin
    idle(20000);
    fails++;
    give_verdict();
  end
endmodule
`default_nettype wire
